// ---- logic/lpm_pkg.sv ----
/*
 * Constants, register map and types of the low-power mode controller.
 * Assumes one 250 MHz clock and an AXI4-Lite master for register access.
 */
// Functional notes
// R1: Level release: leave deep-stop on high stop pin; pin high at command starts warm-up.
// R2: Once warm-up starts, a low stop pin does not restart deep-stop.
// R3: Edge to level switch takes effect only after a stop pin rising edge.
// R4: Edge release: a rising stop pin edge ends deep-stop.
// R5: Edge release: deep-stop is entered even with the stop pin high.
// R6: Deep-stop turns the oscillator off and halts everything; state is held.
// R7: Release first enables the oscillator, then runs warm-up before execution.
// R8: Internal operation stays halted for the whole warm-up.
// R9: Warm-up length comes from a 2-bit field with four settings.
// R10: Warm-up counts: 3*2^16, 2^16, 3*2^14, 2^14 oscillator cycles.
// R11: Warm-up is counted from the oscillator clock via the divider; the code counts aclk cycles in warm_reg, not via the divider.
// R12: Prescaler and timing divider are cleared before restart.
// R13: Execution resumes after the instruction that started deep-stop.
// R14: Reset low during deep-stop ends it at once, no warm-up.
// R15: Software disables interrupts before stop and clears stale latches after.
// R16: CPU-sleep halts CPU and watchdog; peripherals keep running.
// R17: CPU-sleep holds memory, registers, status word and port latches.
// R18: During CPU-sleep the program counter sits two bytes past the sleep instruction.
// R19: Software clears master enable, sets enables, then writes the sleep bit.
// R20: Leaving CPU-sleep clears the sleep bit and restores the previous mode.
// R21: Reset low ends CPU-sleep; execution restarts in single-clock mode.
// R22: Master enable 0: enabled interrupt wakes without being serviced.
// R23: After a non-vectored wake software clears the waking latch.
// R24: Master enable 1: enabled interrupt wakes and is serviced first.
// R25: A watchdog interrupt just before sleep is serviced and sleep is skipped.
// R26: The stop pin is watched by a detector that needs no oscillator; the code samples it with synchronisers clocked by aclk.
package lpm_pkg;
	localparam int unsigned AXI_AW = 4;
	localparam logic [AXI_AW-1:0] CTRL1_OFFSET  = 4'h0;
	localparam logic [AXI_AW-1:0] CTRL2_OFFSET  = 4'h4;
	localparam logic [AXI_AW-1:0] STATUS_OFFSET = 4'h8;
	// Control one fields
	localparam int unsigned C1_STOP_BIT = 7;
	localparam int unsigned C1_RELSEL_BIT = 6;
	localparam int unsigned C1_OUTEN_BIT = 4;
	localparam int unsigned C1_WARMUP_LSB = 2;
	// Control two fields
	localparam int unsigned C2_XEN_BIT  = 7;
	localparam int unsigned C2_IDLE_BIT = 4;
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [7:0] CTRL2_RESET = 8'h80;
	// Warm-up in oscillator cycles of the 250 MHz clock
	localparam int unsigned WARMUP_W = 18;
	localparam logic [WARMUP_W-1:0] WARMUP_CODE0 = 18'h30000;
	localparam logic [WARMUP_W-1:0] WARMUP_CODE1 = 18'h10000;
	localparam logic [WARMUP_W-1:0] WARMUP_CODE2 = 18'h0C000;
	localparam logic [WARMUP_W-1:0] WARMUP_CODE3 = 18'h04000;
	localparam int unsigned PRESCALE_W = 8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned IRQ_W = 8;

	typedef enum logic [1:0] {
		LPM_RUN,
		LPM_STOP,
		LPM_WARMUP,
		LPM_SLEEP
	} lpm_state_type;

	typedef struct packed {
		logic                cpu_halt;
		logic                wdog_halt;
		logic                periph_halt;
		logic                osc_enable;
		logic                divider_clear;
		logic                resume_pulse;
		logic                service_irq;
	} lpm_ctrl_type;
endpackage : lpm_pkg

// ---- logic/lpm_controller.sv ----
/*
 * Deep-stop and CPU-sleep sequencer with an AXI4-Lite register slave.
 * Assumes the stop pin and reset pin arrive asynchronously; irq flags are synchronous.
 */
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module lpm_controller (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [lpm_pkg::AXI_AW-1:0]     s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [lpm_pkg::AXI_AW-1:0]     s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [31:0]                         s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic                           stop_pin,
	input  wire logic                           reset_pin_n,
	input  wire logic                           master_irq_enable,
	input  wire logic [lpm_pkg::IRQ_W-1:0]      irq_enable_flags,
	input  wire logic [lpm_pkg::IRQ_W-1:0]      irq_latches,
	input  wire logic                           watchdog_irq,
	output lpm_pkg::lpm_ctrl_type               ctrl,
	output logic [lpm_pkg::PRESCALE_W-1:0]      prescaler
);
	logic [7:0] ctrl1_reg, ctrl1_next;
	logic [7:0] ctrl2_reg, ctrl2_next;
	lpm_pkg::lpm_state_type state_reg, state_next;
	logic [lpm_pkg::WARMUP_W-1:0] warm_reg, warm_next;
	logic [lpm_pkg::PRESCALE_W-1:0] presc_reg;
	logic stop_s1_reg, stop_s2_reg, stop_s3_reg;
	logic rst_s1_reg, rst_s2_reg;
	logic level_mode_reg;
	logic resume_reg, service_reg;
	logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
	logic [lpm_pkg::AXI_AW-1:0] awaddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [1:0] bresp_reg, rresp_reg;

	// Stop pin and reset pin synchronisers
	always_ff @(posedge aclk) begin
		stop_s1_reg <= stop_pin;
		stop_s2_reg <= stop_s1_reg;
		stop_s3_reg <= stop_s2_reg;
		rst_s1_reg  <= reset_pin_n;
		rst_s2_reg  <= rst_s1_reg;
	end

	wire stop_high = stop_s2_reg;
	wire stop_rise = stop_s2_reg & ~stop_s3_reg;
	wire pin_reset = ~rst_s2_reg;
	wire release_sel = ctrl1_reg[lpm_pkg::C1_RELSEL_BIT];
	wire stop_cmd  = ctrl1_reg[lpm_pkg::C1_STOP_BIT];
	wire sleep_cmd = ctrl2_reg[lpm_pkg::C2_IDLE_BIT];
	wire [1:0] warmup_select = ctrl1_reg[lpm_pkg::C1_WARMUP_LSB +: 2];
	wire wake_irq  = |(irq_enable_flags & irq_latches);

	// Level mode engages only after a rising edge once selected
	always_ff @(posedge aclk) begin
		if (!aresetn || pin_reset) begin
			level_mode_reg <= 1'b0;
		end else if (!release_sel) begin
			level_mode_reg <= 1'b0;
		end else if (stop_rise) begin
			level_mode_reg <= 1'b1; // [R3]
		end
	end

	wire [lpm_pkg::WARMUP_W-1:0] warm_load =
		(warmup_select == 2'h0) ? lpm_pkg::WARMUP_CODE0 :
		(warmup_select == 2'h1) ? lpm_pkg::WARMUP_CODE1 :
		(warmup_select == 2'h2) ? lpm_pkg::WARMUP_CODE2 : lpm_pkg::WARMUP_CODE3; // [R9] [R10]

	// Synchronous edge/level detector on the free-running fabric clock
	wire release_evt = level_mode_reg ? stop_high : stop_rise; // [R1] [R4] [R26]

	// Bus write accepted only while running
	logic wstrb0_reg;
	wire s_axi_wstrb_q = wstrb0_reg;
	wire bus_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg & (state_reg == lpm_pkg::LPM_RUN);

	always_comb begin
		state_next = state_reg;
		warm_next  = warm_reg;
		ctrl1_next = ctrl1_reg;
		ctrl2_next = ctrl2_reg;
		unique case (state_reg)
			lpm_pkg::LPM_RUN: begin
				if (stop_cmd) begin
					warm_next = warm_load;
					if (level_mode_reg && stop_high) begin
						state_next = lpm_pkg::LPM_WARMUP; // [R1]
					end else begin
						state_next = lpm_pkg::LPM_STOP; // [R5] [R6]
					end
				end else if (sleep_cmd) begin
					if (watchdog_irq) begin
						ctrl2_next[lpm_pkg::C2_IDLE_BIT] = 1'b0; // [R25]
					end else begin
						state_next = lpm_pkg::LPM_SLEEP; // [R19]
					end
				end
			end
			lpm_pkg::LPM_STOP: begin
				if (release_evt) begin
					state_next = lpm_pkg::LPM_WARMUP; // [R7]
				end
			end
			lpm_pkg::LPM_WARMUP: begin
				// Pin level ignored here
				if (warm_reg <= 18'h00001) begin
					state_next = lpm_pkg::LPM_RUN; // [R2] [R13]
					ctrl1_next[lpm_pkg::C1_STOP_BIT] = 1'b0;
				end else begin
					warm_next = warm_reg - 18'h00001; // [R11]
				end
			end
			lpm_pkg::LPM_SLEEP: begin
				if (wake_irq) begin
					state_next = lpm_pkg::LPM_RUN;
					ctrl2_next[lpm_pkg::C2_IDLE_BIT] = 1'b0; // [R20]
				end
			end
		endcase
		if (bus_wr && awaddr_reg == lpm_pkg::CTRL1_OFFSET && s_axi_wstrb_q) begin
			ctrl1_next = wdata_reg[7:0];
		end
		if (bus_wr && awaddr_reg == lpm_pkg::CTRL2_OFFSET && s_axi_wstrb_q) begin
			ctrl2_next = wdata_reg[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || pin_reset) begin
			state_reg <= lpm_pkg::LPM_RUN; // [R14] [R21]
			warm_reg  <= '0;
			ctrl1_reg <= lpm_pkg::CTRL1_RESET;
			ctrl2_reg <= lpm_pkg::CTRL2_RESET;
		end else begin
			state_reg <= state_next;
			warm_reg  <= warm_next;
			ctrl1_reg <= ctrl1_next;
			ctrl2_reg <= ctrl2_next;
		end
	end

	// Prescaler frozen in stop, cleared before restart
	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg == lpm_pkg::LPM_WARMUP) begin
			presc_reg <= '0; // [R12]
		end else if (state_reg != lpm_pkg::LPM_STOP) begin
			presc_reg <= presc_reg + 8'h01;
		end
	end

	// Resume and service pulses on return to run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			resume_reg  <= 1'b0;
			service_reg <= 1'b0;
		end else begin
			resume_reg  <= (state_reg != lpm_pkg::LPM_RUN) && (state_next == lpm_pkg::LPM_RUN)
				&& !pin_reset;
			service_reg <= (state_reg == lpm_pkg::LPM_SLEEP) && (state_next == lpm_pkg::LPM_RUN)
				&& master_irq_enable && !pin_reset; // [R22] [R24]
		end
	end

	wire in_stop = (state_reg == lpm_pkg::LPM_STOP) || (state_reg == lpm_pkg::LPM_WARMUP);
	wire osc_on  = (state_reg != lpm_pkg::LPM_STOP) && ctrl2_reg[lpm_pkg::C2_XEN_BIT];
	assign ctrl = '{
		cpu_halt:      in_stop || (state_reg == lpm_pkg::LPM_SLEEP), // [R8] [R16] [R17]
		wdog_halt:     in_stop || (state_reg == lpm_pkg::LPM_SLEEP), // [R16]
		periph_halt:   in_stop, // [R6] [R8]
		osc_enable:    osc_on, // [R6] [R7]
		divider_clear: (state_reg == lpm_pkg::LPM_WARMUP), // [R12]
		resume_pulse:  resume_reg, // [R13] [R18]
		service_irq:   service_reg // [R24]
	};
	assign prescaler = presc_reg;

	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			wstrb0_reg  <= 1'b0;
			bresp_reg   <= lpm_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (bus_wr) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (awaddr_reg == lpm_pkg::CTRL1_OFFSET
					|| awaddr_reg == lpm_pkg::CTRL2_OFFSET) ? lpm_pkg::RESP_OKAY
					: lpm_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end
	assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// AXI4-Lite read channel
	wire [31:0] status_word = {28'h0000000, level_mode_reg, stop_high, state_reg};
	wire [31:0] rd_mux =
		(s_axi_araddr == lpm_pkg::CTRL1_OFFSET)  ? {24'h000000, ctrl1_reg} :
		(s_axi_araddr == lpm_pkg::CTRL2_OFFSET)  ? {24'h000000, ctrl2_reg} :
		(s_axi_araddr == lpm_pkg::STATUS_OFFSET) ? status_word : 32'h00000000;
	wire rd_ok = (s_axi_araddr == lpm_pkg::CTRL1_OFFSET) || (s_axi_araddr == lpm_pkg::CTRL2_OFFSET)
		|| (s_axi_araddr == lpm_pkg::STATUS_OFFSET);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= lpm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_mux;
			rresp_reg  <= rd_ok ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// Checks
	property p_stop_osc_off;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == lpm_pkg::LPM_STOP |-> !ctrl.osc_enable && ctrl.periph_halt;
	endproperty
	a_stop_osc_off: assert property (p_stop_osc_off) else $error("osc on in stop"); // [R6]

	property p_warm_halted;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == lpm_pkg::LPM_WARMUP |-> ctrl.cpu_halt && ctrl.divider_clear;
	endproperty
	a_warm_halted: assert property (p_warm_halted) else $error("not halted in warm-up"); // [R8]

	property p_no_restop;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_WARMUP |=> state_reg != lpm_pkg::LPM_STOP;
	endproperty
	a_no_restop: assert property (p_no_restop) else $error("stop re-entered"); // [R2]

	property p_edge_release;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_STOP && !level_mode_reg && stop_rise
			|=> state_reg == lpm_pkg::LPM_WARMUP;
	endproperty
	a_edge_release: assert property (p_edge_release) else $error("edge release missed"); // [R4]

	property p_reset_exit;
		@(posedge aclk) disable iff (!aresetn)
		pin_reset |=> state_reg == lpm_pkg::LPM_RUN;
	endproperty
	a_reset_exit: assert property (p_reset_exit) else $error("reset did not exit"); // [R14]

	property p_sleep_wake;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_SLEEP && wake_irq
			|=> state_reg == lpm_pkg::LPM_RUN && !ctrl2_reg[lpm_pkg::C2_IDLE_BIT];
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake failed"); // [R20]

	property p_sleep_periph;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == lpm_pkg::LPM_SLEEP |-> ctrl.cpu_halt && ctrl.wdog_halt && !ctrl.periph_halt;
	endproperty
	a_sleep_periph: assert property (p_sleep_periph) else $error("sleep halt wrong"); // [R16]

	property p_wdog_skip;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_RUN && sleep_cmd && !stop_cmd && watchdog_irq
			|=> state_reg != lpm_pkg::LPM_SLEEP;
	endproperty
	a_wdog_skip: assert property (p_wdog_skip) else $error("sleep entered on watchdog"); // [R25]

	property p_level_release;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_STOP && level_mode_reg && stop_high
			|=> state_reg == lpm_pkg::LPM_WARMUP;
	endproperty
	a_level_release: assert property (p_level_release) else $error("level release missed"); // [R1]

	property p_level_direct;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_RUN && stop_cmd && level_mode_reg && stop_high
			|=> state_reg == lpm_pkg::LPM_WARMUP;
	endproperty
	a_level_direct: assert property (p_level_direct) else $error("no direct warm-up"); // [R1]

	property p_edge_enter;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_RUN && stop_cmd && !level_mode_reg
			|=> state_reg == lpm_pkg::LPM_STOP;
	endproperty
	a_edge_enter: assert property (p_edge_enter) else $error("stop not entered"); // [R5]

	property p_level_wait;
		@(posedge aclk) disable iff (!aresetn)
		!level_mode_reg && !stop_rise |=> !level_mode_reg;
	endproperty
	a_level_wait: assert property (p_level_wait) else $error("level mode too early"); // [R3]

	property p_warm_count;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_WARMUP && warm_reg > 18'h00001
			|=> state_reg == lpm_pkg::LPM_WARMUP && warm_reg == $past(warm_reg) - 18'h00001;
	endproperty
	a_warm_count: assert property (p_warm_count) else $error("warm-up count broken"); // [R11]

	property p_warm_end;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_WARMUP && warm_reg <= 18'h00001
			|=> state_reg == lpm_pkg::LPM_RUN && !stop_cmd && ctrl.resume_pulse;
	endproperty
	a_warm_end: assert property (p_warm_end) else $error("no resume after warm-up"); // [R13]

	property p_presc_clear;
		@(posedge aclk) disable iff (!aresetn)
		state_reg == lpm_pkg::LPM_WARMUP |=> prescaler == '0;
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared"); // [R12]

	property p_stop_hold;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_STOP |=> $stable(prescaler) && $stable(ctrl2_reg);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("state changed in stop"); // [R6]

	property p_sleep_hold;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_SLEEP |=> $stable(ctrl1_reg);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("registers moved in sleep"); // [R17]

	property p_sleep_enter;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_RUN && sleep_cmd && !stop_cmd && !watchdog_irq
			|=> state_reg == lpm_pkg::LPM_SLEEP;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered"); // [R19]

	property p_wake_service;
		@(posedge aclk) disable iff (!aresetn || pin_reset)
		state_reg == lpm_pkg::LPM_SLEEP && wake_irq
			|=> ctrl.resume_pulse && ctrl.service_irq == $past(master_irq_enable);
	endproperty
	a_wake_service: assert property (p_wake_service) else $error("wake service wrong"); // [R22] [R24]

	property p_pin_reset_regs;
		@(posedge aclk) disable iff (!aresetn)
		pin_reset |=> ctrl1_reg == lpm_pkg::CTRL1_RESET && ctrl2_reg == lpm_pkg::CTRL2_RESET
			&& !ctrl.resume_pulse;
	endproperty
	a_pin_reset_regs: assert property (p_pin_reset_regs) else $error("reset left state"); // [R21]
endmodule : lpm_controller
`default_nettype wire

// ---- test/lpm_wake_source.sv ----
/*
 * Wake source model: drives the stop pin from the far side of the controller.
 * Assumes the bench calls drive() from its own processes, one call at a time.
 */
`timescale 1ns/100ps
`default_nettype none
module lpm_wake_source (
	input  wire logic aclk,
	output var logic  stop_pin
);
	initial stop_pin = 1'h0;

	// New pin level after a prompt or slow delay in clock edges
	task automatic drive(input logic level, input int dly);
		@(posedge aclk);
		repeat (dly) @(posedge aclk);
		stop_pin <= level;
	endtask : drive
endmodule : lpm_wake_source
`default_nettype wire

// ---- test/tb_lpm_controller.sv ----
/*
 * Self-checking bench of the low-power mode controller.
 * Assumes the package, the controller and the wake source model compile first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_lpm_controller;
	localparam logic [3:0] C1 = lpm_pkg::CTRL1_OFFSET;
	localparam logic [3:0] C2 = lpm_pkg::CTRL2_OFFSET;
	localparam logic [3:0] ST = lpm_pkg::STATUS_OFFSET;
	logic                  aclk = 1'h0;
	logic                  aresetn = 1'h0;
	logic [3:0]            awaddr = 4'h0;
	logic [3:0]            araddr = 4'h0;
	logic [31:0]           wdata = 32'h0;
	logic                  awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic                  arvalid = 1'h0, rready = 1'h0;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp, rs;
	logic [31:0]           rdata, rd;
	logic                  rpin_n = 1'h1, mie = 1'h0, wdi = 1'h0;
	logic [7:0]            ief = 8'h0, ilat = 8'h0, p, presc;
	wire logic             stop_pin;
	lpm_pkg::lpm_ctrl_type ctrl;
	int                    n_mismatch = 0, check_count = 0, cycles = 0;

	lpm_controller uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.stop_pin(stop_pin), .reset_pin_n(rpin_n), .master_irq_enable(mie),
		.irq_enable_flags(ief), .irq_latches(ilat), .watchdog_irq(wdi), .ctrl(ctrl),
		.prescaler(presc)
	);
	lpm_wake_source wk (.aclk(aclk), .stop_pin(stop_pin));

	always #2 aclk = ~aclk;

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 100000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic results;
		if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic axw(input logic [3:0] a, input logic [7:0] d);
		logic aw_ok, w_ok, b_ok;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge aclk);
			aw_ok = awvalid & awready;
			w_ok = wvalid & wready;
			b_ok = bvalid;
			if (b_ok) rs = bresp;
			@(posedge aclk);
			if (aw_ok) awvalid <= 1'h0;
			if (w_ok) wvalid <= 1'h0;
		end while (b_ok !== 1'h1);
		bready <= 1'h0;
	endtask : axw

	task automatic axr(input logic [3:0] a);
		logic ar_ok, r_ok;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge aclk);
			ar_ok = arvalid & arready;
			r_ok = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ar_ok) arvalid <= 1'h0;
		end while (r_ok !== 1'h1);
		rready <= 1'h0;
	endtask : axr

	task automatic st(input logic [1:0] exp);
		axr(ST);
		chk("state", 32'(exp), 32'(rd[1:0]));
	endtask : st

	task automatic pin_rst;
		@(posedge aclk);
		rpin_n <= 1'h0;
		repeat (3) @(posedge aclk);
		rpin_n <= 1'h1;
		repeat (6) @(negedge aclk);
	endtask : pin_rst

	// Follow one warm-up to its resume pulse, counting cycles
	task automatic warm(input int exp);
		int n;
		logic bad;
		n = 0;
		bad = 1'h0;
		while (ctrl.osc_enable !== 1'h1 && n < 20) begin
			@(negedge aclk);
			n++;
		end
		do begin
			@(negedge aclk);
			n++;
			if (ctrl.resume_pulse !== 1'h1 && (ctrl.cpu_halt !== 1'h1
			    || ctrl.osc_enable !== 1'h1 || ctrl.divider_clear !== 1'h1
			    || (presc !== 8'h00 && n > 30))) bad = 1'h1;
		end while (ctrl.resume_pulse !== 1'h1);
		chk("warm halt", 32'h0, 32'(bad));
		chk("warm len", 32'h1, 32'(n >= exp - 8 && n <= exp + 8));
	endtask : warm

	task automatic t_regs;
		axr(C1);
		chk("ctrl1", 32'h00, 32'(rd[7:0]));
		axr(C2);
		chk("ctrl2", 32'h80, 32'(rd[7:0]));
		axr(4'hC);
		chk("rresp", 32'(lpm_pkg::RESP_SLVERR), 32'(rs));
		axw(4'hC, 8'hFF);
		chk("bresp", 32'(lpm_pkg::RESP_SLVERR), 32'(rs));
		axw(C1, 8'h10);
		axr(C1);
		chk("ctrl1 rw", 32'h10, 32'(rd[7:0]));
		axw(C1, 8'h00);
	endtask : t_regs

	task automatic t_edge;
		wk.drive(1'h1, 0);
		axw(C1, 8'h8C);
		repeat (4) @(negedge aclk);
		chk("stop halts", 32'h6, 32'({ctrl.cpu_halt, ctrl.periph_halt, ctrl.osc_enable}));
		st(2'h1);
		p = presc;
		repeat (20) @(negedge aclk);
		chk("presc held", 32'(p), 32'(presc));
		wk.drive(1'h0, 3);
		wk.drive(1'h1, 3);
		warm(int'(lpm_pkg::WARMUP_CODE3));
		axr(C1);
		chk("ctrl1 after", 32'h0C, 32'(rd[7:0]));
		st(2'h0);
	endtask : t_edge

	task automatic t_level;
		wk.drive(1'h0, 0);
		axw(C1, 8'h4C);
		axr(ST);
		chk("level mode", 32'h0, 32'(rd[3]));
		wk.drive(1'h1, 2);
		repeat (4) @(negedge aclk);
		axr(ST);
		chk("level mode", 32'h1, 32'(rd[3]));
		axw(C1, 8'hCC);
		fork
			wk.drive(1'h0, 100);
			warm(int'(lpm_pkg::WARMUP_CODE3));
		join
		axw(C1, 8'hC8);
		repeat (4) @(negedge aclk);
		st(2'h1);
		wk.drive(1'h1, 10);
		warm(int'(lpm_pkg::WARMUP_CODE2));
		axw(C1, 8'h00);
	endtask : t_level

	task automatic t_rst_stop;
		wk.drive(1'h0, 0);
		axw(C1, 8'h80);
		repeat (4) @(negedge aclk);
		chk("in stop", 32'h0, 32'(ctrl.osc_enable));
		pin_rst();
		chk("pin reset", 32'h2, 32'({ctrl.osc_enable, ctrl.cpu_halt}));
		st(2'h0);
	endtask : t_rst_stop

	task automatic t_sleep;
		logic res, svc;
		for (int m = 0; m < 2; m++) begin
			@(posedge aclk);
			mie <= 1'h0;
			ief <= 8'h04;
			axw(C2, 8'h90);
			repeat (3) @(negedge aclk);
			chk("sleep halts", 32'h6, 32'({ctrl.cpu_halt, ctrl.wdog_halt, ctrl.periph_halt}));
			@(posedge aclk);
			mie <= m[0];
			ilat <= 8'h01;
			repeat (6) @(negedge aclk);
			chk("not enabled", 32'h1, 32'(ctrl.cpu_halt));
			@(posedge aclk);
			ilat <= 8'h05;
			res = 1'h0;
			svc = 1'h0;
			repeat (6) begin
				@(negedge aclk);
				res = res | ctrl.resume_pulse;
				svc = svc | ctrl.service_irq;
			end
			chk("woken", 32'h1, 32'(res));
			chk("serviced", 32'(m), 32'(svc));
			@(posedge aclk);
			ilat <= 8'h00;
			axr(C2);
			chk("ctrl2 after", 32'h80, 32'(rd[7:0]));
		end
		@(posedge aclk);
		mie <= 1'h0;
		wdi <= 1'h1;
		axw(C2, 8'h90);
		repeat (3) @(negedge aclk);
		chk("wdog skip", 32'h0, 32'(ctrl.cpu_halt));
		axr(C2);
		chk("wdog bit", 32'h80, 32'(rd[7:0]));
		@(posedge aclk);
		wdi <= 1'h0;
		axw(C2, 8'h90);
		pin_rst();
		chk("sleep reset", 32'h0, 32'(ctrl.cpu_halt));
		st(2'h0);
	endtask : t_sleep

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_edge();
		t_level();
		t_rst_stop();
		t_sleep();
		results();
	end
endmodule : tb_lpm_controller
`default_nettype wire
